// File: core/serial_cfg.svh
// constants for the flexible serial unit and its remote master
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH

// register bus
`define ADDR_W          4
`define DATA_W          32

// device registers, byte offsets
`define DEV_DATA_OFS    4'h0
`define DEV_STAT_OFS    4'h4
`define DEV_CTRL_OFS    4'h8

// device status fields
`define STAT_CNT        3:0
`define STAT_OVF        6
`define STAT_START      7

// device control fields
`define CTRL_WM         1:0
`define CTRL_EDGE       2
`define CTRL_SRC        3
`define CTRL_STROBE     4
`define CTRL_TOGGLE     5
`define CTRL_DO_DIR     6
`define CTRL_SCK_DIR    7

// wire modes
`define WM_OFF          2'h0
`define WM_THREE        2'h1
`define WM_TWO          2'h2
`define WM_TWO_HOLD     2'h3

`define CNT_MAX         4'hf
`define SHREG_RST       8'h00

// remote master registers, byte offsets
`define HOST_DATA_OFS   4'h0
`define HOST_CTRL_OFS   4'h4
`define HOST_STAT_OFS   4'h8

// remote master fields
`define HCTRL_GO        0
`define HCTRL_MODE      1
`define HCTRL_SDA_LOW   2
`define HSTAT_BUSY      0
`define HSTAT_DONE      1

// serial clock half period in system clocks, minus one
`define HALF_CYC        8'd15
`define BITS_LAST       3'h7

`endif

// File: core/serial_pkg.sv
// types shared by both ends of the serial link
package serial_pkg;

  typedef logic [1:0] wire_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_TRAIL
  } host_state_t;

  typedef struct packed {
    logic [2:0]  sck_s;
    logic [2:0]  di_s;
    logic [2:0]  sda_s;
    logic        sck_lvl;
    logic        di_lvl;
    logic        sda_lvl;
    logic [7:0]  shreg;
    logic [3:0]  cnt;
    logic        ovf;
    logic        start;
    wire_mode_t  wm;
    logic        edge_sel;
    logic        src_sel;
    logic        strobe_bit;
    logic        do_dir;
    logic        sck_dir;
    logic        sck_port;
    logic        do_latch;
    logic        hold;
    logic        do_o;
    logic        do_oe;
    logic        sda_oe;
    logic        sck_o;
    logic        sck_oe;
    logic        wait_req;
    logic [31:0] rdata;
  } dev_state_t;

  typedef struct packed {
    host_state_t state;
    logic [2:0]  di_s;
    logic        di_lvl;
    logic [7:0]  sh;
    logic [7:0]  half;
    logic [2:0]  bits;
    logic        mode;
    logic        done;
    logic        do_o;
    logic        sck_o;
    logic        sck_oe;
    logic        sda_oe;
    logic        wait_req;
    logic [31:0] rdata;
  } host_st_t;

endpackage : serial_pkg

// File: core/serial_link_if.sv
// pins between the flexible serial unit and the remote master
`timescale 1ns/10ps
`default_nettype none

interface serial_link_if;
  // device drives
  logic dev_do;
  logic dev_do_oe;
  logic dev_sda_oe;
  logic dev_sck_o;
  logic dev_sck_oe;
  // remote drives
  logic rem_do;
  logic rem_sck_o;
  logic rem_sck_oe;
  logic rem_sda_oe;
  // resolved wires
  wire  sck;
  wire  sda;
  wire  dev_di;
  wire  rem_di;

  // clock and sda lines are wired-and with a pull-up
  assign sck    = ~((dev_sck_oe & ~dev_sck_o) | (rem_sck_oe & ~rem_sck_o));
  assign sda    = ~(dev_sda_oe | rem_sda_oe);
  assign dev_di = rem_do;
  assign rem_di = dev_do_oe ? dev_do : 1'b1;

  modport device (
    input  sck, sda, dev_di,
    output dev_do, dev_do_oe, dev_sda_oe, dev_sck_o, dev_sck_oe
  );

  modport remote (
    input  sck, rem_di,
    output rem_do, rem_sck_o, rem_sck_oe, rem_sda_oe
  );
endinterface : serial_link_if

`default_nettype wire

// File: core/remote_serial_master.sv
// remote serial master: clocks one byte out and in per request
`timescale 1ns/10ps
`default_nettype none
`include "serial_cfg.svh"

module remote_serial_master (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // avalon slave
  input  wire logic [`ADDR_W-1:0]   ADDRESS,
  input  wire logic                 READ,
  input  wire logic                 WRITE,
  input  wire logic [`DATA_W-1:0]   WRITEDATA,
  output logic      [`DATA_W-1:0]   READDATA,
  output logic                      WAITREQUEST,
  // link
  serial_link_if.remote             LINK
);

  serial_pkg::host_st_t r;
  serial_pkg::host_st_t n;

  logic take;
  logic wr_data;
  logic wr_ctrl;
  logic wr_stat;
  logic done_set;

  always_comb begin
    n        = r;
    take     = (READ | WRITE) & ~r.wait_req;
    wr_data  = take & WRITE & (ADDRESS == `HOST_DATA_OFS);
    wr_ctrl  = take & WRITE & (ADDRESS == `HOST_CTRL_OFS);
    wr_stat  = take & WRITE & (ADDRESS == `HOST_STAT_OFS);
    done_set = 1'b0;
    n.wait_req = ~((READ | WRITE) & r.wait_req);
    n.di_s     = {r.di_s[1:0], LINK.rem_di};
    if (r.di_s[1] == r.di_s[2]) begin
      n.di_lvl = r.di_s[2];
    end
    n.sck_oe = 1'b1;
    if (wr_ctrl) begin
      n.sda_oe = WRITEDATA[`HCTRL_SDA_LOW];
    end
    case (r.state)
      serial_pkg::ST_IDLE: begin
        // data and mode are frozen while a byte is in flight
        if (wr_data) begin
          n.sh = WRITEDATA[7:0];
        end
        if (wr_ctrl) begin
          n.mode = WRITEDATA[`HCTRL_MODE];
        end
        if (wr_ctrl && WRITEDATA[`HCTRL_GO]) begin
          n.do_o  = r.sh[7];
          n.half  = 8'h00;
          n.bits  = 3'h0;
          n.state = serial_pkg::ST_LEAD;
        end
      end
      serial_pkg::ST_LEAD: begin
        if (r.half == `HALF_CYC) begin
          n.half  = 8'h00;
          n.sck_o = 1'b1;
          n.state = serial_pkg::ST_TRAIL;
          if (r.mode) begin
            n.do_o = r.sh[7];
          end else begin
            n.sh = {r.sh[6:0], r.di_lvl};
          end
        end else begin
          n.half = r.half + 8'h01;
        end
      end
      serial_pkg::ST_TRAIL: begin
        if (r.half == `HALF_CYC) begin
          n.half  = 8'h00;
          n.sck_o = 1'b0;
          n.bits  = r.bits + 3'h1;
          if (r.mode) begin
            n.sh = {r.sh[6:0], r.di_lvl};
          end else begin
            n.do_o = r.sh[7];
          end
          // eight pulses swap the two bytes
          if (r.bits == `BITS_LAST) begin
            n.state  = serial_pkg::ST_IDLE;
            done_set = 1'b1;
          end else begin
            n.state = serial_pkg::ST_LEAD;
          end
        end else begin
          n.half = r.half + 8'h01;
        end
      end
      default: begin
        n.state = serial_pkg::ST_IDLE;
      end
    endcase
    n.done  = done_set | (r.done & ~(wr_stat & WRITEDATA[`HSTAT_DONE]));
    n.rdata = '0;
    case (ADDRESS)
      `HOST_DATA_OFS: n.rdata[7:0] = r.sh;
      `HOST_CTRL_OFS: begin
        n.rdata[`HCTRL_MODE]    = r.mode;
        n.rdata[`HCTRL_SDA_LOW] = r.sda_oe;
      end
      `HOST_STAT_OFS: begin
        n.rdata[`HSTAT_BUSY] = (r.state != serial_pkg::ST_IDLE);
        n.rdata[`HSTAT_DONE] = r.done;
      end
      default: n.rdata = '0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      r          <= '0;
      r.state    <= serial_pkg::ST_IDLE;
      r.di_s     <= 3'h7;
      r.di_lvl   <= 1'b1;
      r.wait_req <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign READDATA        = r.rdata;
  assign WAITREQUEST     = r.wait_req;
  assign LINK.rem_do     = r.do_o;
  assign LINK.rem_sck_o  = r.sck_o;
  assign LINK.rem_sck_oe = r.sck_oe;
  assign LINK.rem_sda_oe = r.sda_oe;

endmodule : remote_serial_master

`default_nettype wire

// File: core/flex_serial_unit.sv
// flexible serial unit: shift register, edge counter, clock and start control
`timescale 1ns/10ps
`default_nettype none
`include "serial_cfg.svh"

// Operation
// - software reads and writes unbuffered 8-bit shifter
// - shifter top bit drives pin chosen by mode
// - output latch changes on opposite clock edge
// - serial input always from data input pin
// - 4-bit counter, readable, writable, overflow request
// - shifter and counter share one clock event with timer or strobe source
// - external clock counts both edges
// - clock from pin, timer match or strobe
// - start condition raises request
// - hold clock low after start or overflow
// - three-wire modes 0 and 1, no select
// - eight clocks swap both shift registers
// - master makes the serial clock
// - mode 0 samples rising, mode 1 falling
// - data ready half period before sampling
// - software clears counter before each byte
// - sixteen external edges overflow, byte done
// - overflow request wakes idle processor
// - toggle strobe counts with external edge setting
// - back-to-back strobes reach half clock rate
// - data write beats simultaneous shift
// - start detector only in two-wire mode
module flex_serial_unit (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // avalon slave
  input  wire logic [`ADDR_W-1:0]   ADDRESS,
  input  wire logic                 READ,
  input  wire logic                 WRITE,
  input  wire logic [`DATA_W-1:0]   WRITEDATA,
  output logic      [`DATA_W-1:0]   READDATA,
  output logic                      WAITREQUEST,
  // timer compare match, same clock domain
  input  wire logic                 TIMER_MATCH,
  // requests
  output logic                      OVF_IRQ,
  output logic                      START_IRQ,
  // link
  serial_link_if.device             LINK
);

  serial_pkg::dev_state_t r;
  serial_pkg::dev_state_t n;

  logic take;
  logic wr_data;
  logic wr_stat;
  logic wr_ctrl;
  logic strobe_w;
  logic toggle_w;
  logic sck_rise;
  logic sck_fall;
  logic sda_fall;
  logic shift_ev;
  logic count_ev;
  logic ovf_set;
  logic start_set;
  logic two_wire;
  logic transparent;

  always_comb begin
    n        = r;
    take     = (READ | WRITE) & ~r.wait_req;
    wr_data  = take & WRITE & (ADDRESS == `DEV_DATA_OFS);
    wr_stat  = take & WRITE & (ADDRESS == `DEV_STAT_OFS);
    wr_ctrl  = take & WRITE & (ADDRESS == `DEV_CTRL_OFS);
    // one write per two cycles caps strobed clock at half rate
    strobe_w = wr_ctrl & WRITEDATA[`CTRL_STROBE];
    toggle_w = wr_ctrl & WRITEDATA[`CTRL_TOGGLE];
    two_wire = r.wm[1];
    n.wait_req = ~((READ | WRITE) & r.wait_req);

    // pin inputs: a change counts once second and third stages agree
    n.sck_s = {r.sck_s[1:0], LINK.sck};
    n.di_s  = {r.di_s[1:0], LINK.dev_di};
    n.sda_s = {r.sda_s[1:0], LINK.sda};
    if (r.sck_s[1] == r.sck_s[2]) begin
      n.sck_lvl = r.sck_s[2];
    end
    if (r.di_s[1] == r.di_s[2]) begin
      n.di_lvl = r.di_s[2];
    end
    if (r.sda_s[1] == r.sda_s[2]) begin
      n.sda_lvl = r.sda_s[2];
    end
    sck_rise = n.sck_lvl & ~r.sck_lvl;
    sck_fall = ~n.sck_lvl & r.sck_lvl;
    sda_fall = ~n.sda_lvl & r.sda_lvl;

    // clock source select
    if (r.src_sel) begin
      shift_ev = r.edge_sel ? sck_fall : sck_rise;
    end else begin
      shift_ev = r.edge_sel ? TIMER_MATCH : strobe_w;
    end
    if (r.src_sel) begin
      if (r.strobe_bit) begin
        count_ev = toggle_w;
      end else begin
        count_ev = sck_rise | sck_fall;
      end
    end else begin
      count_ev = shift_ev;
    end

    // shift register, a write wins over a shift in the same cycle
    if (wr_data) begin
      n.shreg = WRITEDATA[7:0];
    end else if (shift_ev) begin
      n.shreg = {r.shreg[6:0], r.di_lvl};
    end

    // counter and overflow, hardware set wins over software clear
    ovf_set = count_ev & (r.cnt == `CNT_MAX);
    if (wr_stat) begin
      n.cnt = WRITEDATA[`STAT_CNT];
    end else if (count_ev) begin
      n.cnt = r.cnt + 4'h1;
    end
    n.ovf = ovf_set | (r.ovf & ~(wr_stat & WRITEDATA[`STAT_OVF]));

    // start condition: data falls while clock high
    start_set = two_wire & sda_fall & r.sck_lvl;
    n.start   = start_set | (r.start & ~(wr_stat & WRITEDATA[`STAT_START]));

    // control
    if (wr_ctrl) begin
      n.wm         = WRITEDATA[`CTRL_WM];
      n.edge_sel   = WRITEDATA[`CTRL_EDGE];
      n.src_sel    = WRITEDATA[`CTRL_SRC];
      n.strobe_bit = WRITEDATA[`CTRL_STROBE];
      n.do_dir     = WRITEDATA[`CTRL_DO_DIR];
      n.sck_dir    = WRITEDATA[`CTRL_SCK_DIR];
    end
    if (toggle_w) begin
      n.sck_port = ~r.sck_port;
    end

    // latch open only in the output-change half of the clock
    // closes on the sampling edge itself, else the shifted bit leaks out early
    transparent = (n.sck_lvl == r.edge_sel);
    if (transparent) begin
      n.do_latch = n.shreg[7];
    end

    // clock stretch; released once the flag is cleared
    n.hold = two_wire & ~r.sck_lvl
           & (r.start | ((r.wm == `WM_TWO_HOLD) & r.ovf));

    // pin drive: data out pin in three-wire, open-drain data in two-wire
    n.do_o   = r.do_latch;
    n.do_oe  = r.do_dir & ~two_wire;
    n.sda_oe = two_wire & r.do_dir & ~r.do_latch;
    if (two_wire) begin
      n.sck_o  = 1'b0;
      n.sck_oe = (r.sck_dir & ~r.sck_port) | r.hold;
    end else begin
      n.sck_o  = r.sck_port;
      n.sck_oe = r.sck_dir;
    end

    // read back
    n.rdata = '0;
    case (ADDRESS)
      `DEV_DATA_OFS: n.rdata[7:0] = r.shreg;
      `DEV_STAT_OFS: begin
        n.rdata[`STAT_CNT]   = r.cnt;
        n.rdata[`STAT_OVF]   = r.ovf;
        n.rdata[`STAT_START] = r.start;
      end
      `DEV_CTRL_OFS: begin
        n.rdata[`CTRL_WM]      = r.wm;
        n.rdata[`CTRL_EDGE]    = r.edge_sel;
        n.rdata[`CTRL_SRC]     = r.src_sel;
        n.rdata[`CTRL_STROBE]  = r.strobe_bit;
        n.rdata[`CTRL_DO_DIR]  = r.do_dir;
        n.rdata[`CTRL_SCK_DIR] = r.sck_dir;
      end
      default: n.rdata = '0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      r          <= '0;
      r.sck_s    <= 3'h0;
      r.di_s     <= 3'h7;
      r.sda_s    <= 3'h7;
      r.di_lvl   <= 1'b1;
      r.sda_lvl  <= 1'b1;
      r.shreg    <= `SHREG_RST;
      r.wm       <= `WM_OFF;
      r.wait_req <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign READDATA        = r.rdata;
  assign WAITREQUEST     = r.wait_req;
  // also serves as the idle wake request
  assign OVF_IRQ         = r.ovf;
  assign START_IRQ       = r.start;
  assign LINK.dev_do     = r.do_o;
  assign LINK.dev_do_oe  = r.do_oe;
  assign LINK.dev_sda_oe = r.sda_oe;
  assign LINK.dev_sck_o  = r.sck_o;
  assign LINK.dev_sck_oe = r.sck_oe;

endmodule : flex_serial_unit

`default_nettype wire

// File: test/serial_link_assertions.sv
// pin level checks on the link between the serial unit and the remote master
`timescale 1ns/10ps
`default_nettype none

module serial_link_assertions (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // link pins
  input wire logic sck,
  input wire logic rem_do,
  input wire logic rem_sck_oe,
  input wire logic dev_do,
  input wire logic dev_do_oe
);
  logic [5:0] low_run_r;
  logic [3:0] rises_r;

  // a long low run marks the gap between frames
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      low_run_r <= 6'h00;
      rises_r   <= 4'h0;
    end else begin
      if (sck) begin
        low_run_r <= 6'h00;
      end else if (low_run_r != 6'h28) begin
        low_run_r <= low_run_r + 6'h01;
      end
      if (low_run_r == 6'h27) begin
        rises_r <= 4'h0;
      end else if ($rose(sck)) begin
        rises_r <= rises_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_rem_sck_held: assert property (!$past(RST) |-> rem_sck_oe)
    else $error("remote does not drive the clock");
  chk_sck_high_half: assert property ($rose(sck) |-> sck[*8] ##1 sck[*8] ##1 !sck)
    else $error("clock high phase not 16 cycles");
  chk_sck_low_half: assert property ($fell(sck) |-> !sck[*8] ##1 !sck[*8])
    else $error("clock low phase under 16 cycles");
  chk_rem_do_hold: assert property ($changed(rem_do) |=> $stable(rem_do)[*8])
    else $error("remote data changed too soon");
  chk_dev_do_hold: assert property (dev_do_oe && $changed(dev_do) |=> $stable(dev_do)[*8])
    else $error("device data changed too soon");
  chk_rem_setup: assert property (sck != $past(sck) |-> $past(rem_do, 1) == $past(rem_do, 8))
    else $error("remote data not set up before edge");
  chk_dev_setup: assert property (dev_do_oe && sck != $past(sck) |-> $past(dev_do, 1) == $past(dev_do, 8))
    else $error("device data not set up before edge");
  chk_frame_pulses: assert property (low_run_r == 6'h27 |-> rises_r == 4'h0 || rises_r == 4'h8)
    else $error("frame without eight clock pulses");

  cover property ($rose(sck));
  cover property (low_run_r == 6'h27 && rises_r == 4'h8);
  cover property (dev_do_oe && $changed(dev_do));
endmodule : serial_link_assertions

`default_nettype wire

// File: test/tb_top.sv
// bench: software on both ends swaps bytes, strobes and timer counts
`timescale 1ns/10ps
`default_nettype none
`include "serial_cfg.svh"

module tb_top;
  localparam int DEV = 0;
  localparam int REM = 1;
  logic        clock;
  logic        rst;
  logic        tmr;
  logic        ovf_irq;
  logic        start_irq;
  logic [3:0]  adr [2];
  logic        rd [2];
  logic        wr [2];
  logic [31:0] wd [2];
  logic [31:0] rdat [2];
  logic        wt [2];
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] d;
  logic [31:0] byte_q [$];
  int          err_total;
  int          n_compared;
  int          n;
  int          cnt;

  serial_link_if ln ();

  flex_serial_unit i_flex_serial_unit (.CLOCK(clock), .RST(rst), .ADDRESS(adr[0]),
    .READ(rd[0]), .WRITE(wr[0]), .WRITEDATA(wd[0]), .READDATA(rdat[0]),
    .WAITREQUEST(wt[0]), .TIMER_MATCH(tmr), .OVF_IRQ(ovf_irq), .START_IRQ(start_irq),
    .LINK(ln.device));

  remote_serial_master i_remote_serial_master (.CLOCK(clock), .RST(rst), .ADDRESS(adr[1]),
    .READ(rd[1]), .WRITE(wr[1]), .WRITEDATA(wd[1]), .READDATA(rdat[1]),
    .WAITREQUEST(wt[1]), .LINK(ln.remote));

  serial_link_assertions i_serial_link_assertions (.CLOCK(clock), .RST(rst), .sck(ln.sck),
    .rem_do(ln.rem_do), .rem_sck_oe(ln.rem_sck_oe), .dev_do(ln.dev_do),
    .dev_do_oe(ln.dev_do_oe));

  always #5 clock = ~clock;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // gap after each access keeps the pins quiet long enough for the hold checks
  task automatic acc(input int s, input logic [3:0] a, input bit r, input logic [31:0] w);
    int k;
    k = 0;
    adr[s] <= a;
    rd[s] <= r;
    wr[s] <= !r;
    wd[s] <= w;
    do begin
      @(posedge clock);
      k++;
    end while (wt[s] !== 1'b0 && k < 64);
    q = rdat[s];
    if (k >= 64) err_total++;
    rd[s] <= 1'b0;
    wr[s] <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : acc

  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    tmr = 1'b0;
    err_total = 0;
    n_compared = 0;
    seed = 32'h0000_2135;
    for (int i = 0; i < 2; i++) begin
      adr[i] = 4'h0;
      rd[i] = 1'b0;
      wr[i] = 1'b0;
      wd[i] = 32'h0;
    end
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    acc(DEV, 4'hc, 1'b0, 32'hffff_ffff);
    for (int a = 0; a < 16; a += 4) begin
      acc(DEV, 4'(a), 1'b1, 32'h0);
      check("dev reg after reset", q, 32'h0);
    end
    for (int m = 0; m < 2; m++) begin
      byte_q.push_back(xs() & 32'hff);
      byte_q.push_back(xs() & 32'hff);
      acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h49 + 32'(4 * m));
      acc(DEV, `DEV_DATA_OFS, 1'b0, byte_q[0]);
      acc(DEV, `DEV_STAT_OFS, 1'b0, 32'h40);
      acc(DEV, `DEV_DATA_OFS, 1'b1, 32'h0);
      check("dev data load", q, byte_q[0]);
      acc(REM, `HOST_DATA_OFS, 1'b0, byte_q[1]);
      acc(REM, `HOST_CTRL_OFS, 1'b0, 32'h1 + 32'(2 * m));
      n = 0;
      q = 32'h0;
      while (q[`HSTAT_DONE] !== 1'b1 && n < 100) begin
        acc(REM, `HOST_STAT_OFS, 1'b1, 32'h0);
        n++;
      end
      check("remote done", {31'h0, q[`HSTAT_DONE]}, 32'h1);
      repeat (10) @(posedge clock);
      check("overflow request", {31'h0, ovf_irq}, 32'h1);
      acc(DEV, `DEV_STAT_OFS, 1'b1, 32'h0);
      check("dev status", q, 32'h40);
      acc(DEV, `DEV_DATA_OFS, 1'b1, 32'h0);
      check("dev rx byte", q, byte_q[1]);
      acc(REM, `HOST_DATA_OFS, 1'b1, 32'h0);
      check("remote rx byte", q, byte_q[0]);
      void'(byte_q.pop_front());
      void'(byte_q.pop_front());
      acc(REM, `HOST_STAT_OFS, 1'b0, 32'h2);
      acc(DEV, `DEV_STAT_OFS, 1'b0, 32'h40);
      check("overflow cleared", {31'h0, ovf_irq}, 32'h0);
    end
    d = xs() & 32'hff;
    // source bits act from the next write on, so park on strobe source first
    acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h0);
    acc(DEV, `DEV_DATA_OFS, 1'b0, d);
    acc(DEV, `DEV_STAT_OFS, 1'b0, 32'h40);
    cnt = 0;
    for (int k = 1; k <= 16; k++) begin
      acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h10);
      cnt = (cnt + 1) % 16;
      d = ((d << 1) | {31'h0, ln.dev_di}) & 32'hff;
      acc(DEV, `DEV_STAT_OFS, 1'b1, 32'h0);
      check("strobe count", q, 32'(cnt) | (k == 16 ? 32'h40 : 32'h0));
      acc(DEV, `DEV_DATA_OFS, 1'b1, 32'h0);
      check("strobe shift", q, d);
    end
    acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h04);
    acc(DEV, `DEV_STAT_OFS, 1'b0, 32'h40);
    // timer pulses with random spacing, a single cycle each
    for (int k = 0; k < 3; k++) begin
      tmr <= 1'b1;
      @(posedge clock);
      tmr <= 1'b0;
      repeat (2 + xs() % 5) @(posedge clock);
    end
    acc(DEV, `DEV_STAT_OFS, 1'b1, 32'h0);
    check("timer count", q, 32'h3);
    // toggle writes counted instead of pin edges
    acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h18);
    acc(DEV, `DEV_STAT_OFS, 1'b0, 32'h40);
    n = 1 + int'(xs() % 7);
    for (int k = 0; k < n; k++) begin
      acc(DEV, `DEV_CTRL_OFS, 1'b0, 32'h38);
    end
    acc(DEV, `DEV_STAT_OFS, 1'b1, 32'h0);
    check("toggle count", q, 32'(n));
    check("no start outside two-wire", {31'h0, start_irq}, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
